// ### otpp_programmer.sv
// Purpose: Drives an OTP ROM through its pins: program, compare, identify.
// Assumes: External switches set the supplies from the select outputs.
// Notes:   Data pins are split into in, out and enable; enable high drives.
`timescale 1ns/10ps
`include "otpp_params.svh"
module otpp_programmer #(
  parameter int unsigned PULSE_CYC = `OTPP_PULSE_CYC
) (
  // Clock and reset
  input  wire logic        CLK_IN,
  input  wire logic        RSTN_IN,
  // User command
  input  wire logic        START_IN,
  input  wire logic [1:0]  CMD_IN,
  input  wire logic [13:0] FIRST_ADDR_IN,
  input  wire logic [13:0] LAST_ADDR_IN,
  input  wire logic [7:0]  WDATA_IN,
  // User status
  output logic             BUSY_OUT,
  output logic             DONE_OUT,
  output logic             FAIL_OUT,
  output logic             DATA_REQ_OUT,
  output logic [13:0]      CUR_ADDR_OUT,
  output logic [7:0]       RDATA_OUT,
  output logic             RDATA_VALID_OUT,
  output logic             PARITY_OK_OUT,
  output logic [4:0]       TRIES_OUT,
  // Device pins
  output logic [13:0]      ADDR_OUT,
  output logic             CHIP_SEL_N_OUT,
  output logic             OUT_GATE_N_OUT,
  output logic             PROGRAM_STROBE_N_OUT,
  output logic             VCC_HIGH_OUT,
  output logic             VPP_HIGH_OUT,
  output logic             SIGNATURE_SELECT_RAISE_OUT,
  input  wire logic [7:0]  DQ_IN,
  output logic [7:0]       DQ_OUT,
  output logic             DQ_OE_OUT
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    S_IDLE, S_SETUP, S_LOAD, S_PULSE, S_VSET, S_VREAD, S_OVER,
    S_NEXT, S_RSET, S_RREAD, S_FINISH
  } otpp_state_type;

  otpp_state_type     st_q;
  otpp_pkg::otpp_cmd_type cmd_q;
  logic [13:0]        addr_q;
  logic [13:0]        last_q;
  logic [7:0]         wdata_q;
  logic [4:0]         tries_q;
  logic               tload_q;
  logic [31:0]        tcount_q;
  logic               fail_q;
  logic [7:0]         dq_s1_q;
  logic [7:0]         dq_s2_q;
  logic               t_done;

  otpp_pkg::otpp_ctrl_type   ctrl_d;
  otpp_pkg::otpp_supply_type sup_d;

  // ----------------------------------------------------------------
  // Pin synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_IN) begin
    dq_s1_q <= DQ_IN;
    dq_s2_q <= dq_s1_q;
  end

  otpp_timer u_timer (
    .clk_in   (CLK_IN),
    .rstn_in  (RSTN_IN),
    .load_in  (tload_q),
    .count_in (tcount_q),
    .done_out (t_done)
  );

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire is_prog  = (cmd_q == otpp_pkg::OTPP_CMD_PROGRAM);
  wire is_ident = (cmd_q == otpp_pkg::OTPP_CMD_IDENT);
  // Only zeros need programming; a byte already matching passes its first verify, after one pulse.
  wire match    = (dq_s2_q == wdata_q);
  wire odd_par  = ^dq_s2_q;
  wire last_one = (addr_q == last_q);
  wire in_prog_seq = is_prog && (st_q != S_IDLE) && (st_q != S_FINISH);
  wire strobe_on   = (st_q == S_PULSE) || (st_q == S_OVER);
  wire read_on     = (st_q == S_VSET) || (st_q == S_VREAD) ||
                     (st_q == S_RSET) || (st_q == S_RREAD);
  wire [31:0] over_cyc = PULSE_CYC * `OTPP_OVER_FACTOR * {27'h0, tries_q};
  // The strobe pin stays low two cycles longer than the timer count, so
  // each pulse load is two short of the wanted width; PULSE_CYC must be >= 3.
  wire [31:0] pulse_len = PULSE_CYC - 32'h0000_0002;
  wire [31:0] over_len  = over_cyc - 32'h0000_0002;
  // Identification: keep every address line low except the byte select.
  wire [13:0] pin_addr = is_ident ?
       {13'h0000, addr_q[`OTPP_ID_SEL_BIT]} : addr_q;

  // Chip select low only inside an active sequence, so parallel parts with
  // chip select high stay inhibited.
  assign ctrl_d.ce_n  = (st_q == S_IDLE) || (st_q == S_FINISH);
  // Strobe low only while gate is high: program mode, never verify mode.
  assign ctrl_d.pgm_n = !strobe_on;
  assign ctrl_d.oe_n  = !read_on;
  // Supplies raised for the fast sequence, normal for final compare.
  assign sup_d.vcc_high  = in_prog_seq;
  assign sup_d.vpp_high  = in_prog_seq;
  assign sup_d.sig_raise = is_ident && (st_q != S_IDLE) &&
                           (st_q != S_FINISH);

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_IN) begin
    if (!RSTN_IN) begin
      st_q <= S_IDLE;
      cmd_q <= otpp_pkg::OTPP_CMD_NONE;
      addr_q <= 14'h0000;
      last_q <= 14'h0000;
      wdata_q <= 8'hFF;
      tries_q <= 5'h00;
      tload_q <= 1'b0;
      tcount_q <= 32'h0000_0000;
      fail_q <= 1'b0;
      DATA_REQ_OUT <= 1'b0;
      DONE_OUT <= 1'b0;
      RDATA_OUT <= 8'h00;
      RDATA_VALID_OUT <= 1'b0;
      PARITY_OK_OUT <= 1'b0;
    end else begin
      tload_q <= 1'b0;
      DATA_REQ_OUT <= 1'b0;
      DONE_OUT <= 1'b0;
      RDATA_VALID_OUT <= 1'b0;
      unique case (st_q)
        S_IDLE: begin
          if (START_IN && CMD_IN != 2'h3) begin
            cmd_q <= otpp_pkg::otpp_cmd_type'(CMD_IN);
            addr_q <= FIRST_ADDR_IN;
            last_q <= LAST_ADDR_IN;
            wdata_q <= WDATA_IN;
            fail_q <= 1'b0;
            tries_q <= 5'h00;
            tcount_q <= 32'(`OTPP_SETUP_CYC);
            tload_q <= 1'b1;
            st_q <= S_SETUP;
          end
        end
        S_SETUP: begin
          if (t_done) begin
            st_q <= is_prog ? S_LOAD : S_RSET;
          end
        end
        S_LOAD: begin
          tcount_q <= pulse_len;
          tload_q <= 1'b1;
          tries_q <= tries_q + 5'h01;
          st_q <= S_PULSE;
        end
        S_PULSE: begin
          if (t_done) begin
            tcount_q <= 32'(`OTPP_ACCESS_CYC);
            tload_q <= 1'b1;
            st_q <= S_VSET;
          end
        end
        S_VSET: begin
          if (t_done) begin
            tcount_q <= 32'h0000_0003;
            tload_q <= 1'b1;
            st_q <= S_VREAD;
          end
        end
        S_VREAD: begin
          if (t_done) begin
            if (match) begin
              tcount_q <= over_len;
              tload_q <= 1'b1;
              st_q <= S_OVER;
            end else if (tries_q == `OTPP_MAX_TRIES) begin
              fail_q <= 1'b1;
              st_q <= S_FINISH;
            end else begin
              st_q <= S_LOAD;
            end
          end
        end
        S_OVER: begin
          if (t_done) begin
            st_q <= S_NEXT;
          end
        end
        S_NEXT: begin
          if (last_one) begin
            st_q <= S_FINISH;
          end else if (START_IN) begin
            addr_q <= addr_q + 14'h0001;
            wdata_q <= WDATA_IN;
            tries_q <= 5'h00;
            st_q <= S_LOAD;
          end else begin
            DATA_REQ_OUT <= 1'b1;
          end
        end
        S_RSET: begin
          tcount_q <= 32'(`OTPP_ACCESS_CYC + 3);
          tload_q <= 1'b1;
          st_q <= S_RREAD;
        end
        S_RREAD: begin
          if (t_done) begin
            RDATA_OUT <= dq_s2_q;
            RDATA_VALID_OUT <= 1'b1;
            PARITY_OK_OUT <= odd_par;
            if (last_one) begin
              st_q <= S_FINISH;
            end else begin
              addr_q <= addr_q + 14'h0001;
              st_q <= S_RSET;
            end
          end
        end
        S_FINISH: begin
          DONE_OUT <= 1'b1;
          cmd_q <= otpp_pkg::OTPP_CMD_NONE;
          st_q <= S_IDLE;
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registered pins
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_IN) begin
    if (!RSTN_IN) begin
      ADDR_OUT <= 14'h0000;
      CHIP_SEL_N_OUT <= 1'b1;
      OUT_GATE_N_OUT <= 1'b1;
      PROGRAM_STROBE_N_OUT <= 1'b1;
      VCC_HIGH_OUT <= 1'b0;
      VPP_HIGH_OUT <= 1'b0;
      SIGNATURE_SELECT_RAISE_OUT <= 1'b0;
      DQ_OUT <= 8'hFF;
      DQ_OE_OUT <= 1'b0;
      BUSY_OUT <= 1'b0;
      FAIL_OUT <= 1'b0;
      CUR_ADDR_OUT <= 14'h0000;
      TRIES_OUT <= 5'h00;
    end else begin
      ADDR_OUT <= pin_addr;
      CHIP_SEL_N_OUT <= ctrl_d.ce_n;
      OUT_GATE_N_OUT <= ctrl_d.oe_n;
      PROGRAM_STROBE_N_OUT <= ctrl_d.pgm_n;
      VCC_HIGH_OUT <= sup_d.vcc_high;
      VPP_HIGH_OUT <= sup_d.vpp_high;
      SIGNATURE_SELECT_RAISE_OUT <= sup_d.sig_raise;
      DQ_OUT <= wdata_q;
      // Drive data only around the pulses, never while the gate is low.
      DQ_OE_OUT <= is_prog && (st_q == S_LOAD || strobe_on);
      BUSY_OUT <= (st_q != S_IDLE);
      FAIL_OUT <= fail_q;
      CUR_ADDR_OUT <= addr_q;
      TRIES_OUT <= tries_q;
    end
  end

endmodule : otpp_programmer

// ### otpp_params.svh
// Purpose: Timing counts, pin fields and levels for the OTP ROM programmer.
// Assumes: 100 MHz CLK_IN, one cycle is 10 ns.
// Notes:   Supply levels are selects for external switches, not voltages.
//
// Contract
// - Programming needs high program supply, chip select low, strobe low.
// - Programmer drives eight data bits and address during programming.
// - Each initial program pulse lasts one millisecond within tolerance.
// - Count initial pulses per byte; apply at most twenty-five.
// - After verify passes, one overprogram pulse of three ms times count.
// - Pulses and verifies run with main supply six volts, program high.
// - Afterwards compare every byte with both supplies at five volts.
// - Only a device with chip select pulsed low is programmed; code holds it low per sequence and pulses the strobe.
// - Verify: gate low, select low, strobe high, program supply high.
// - Identification needs raised signature line, select and gate low.
// - During identification all other address lines are held low.
`ifndef OTPP_PARAMS_SVH
`define OTPP_PARAMS_SVH

`define OTPP_CLK_MHZ        100
`define OTPP_PULSE_US       1000
`define OTPP_PULSE_CYC      (`OTPP_PULSE_US * `OTPP_CLK_MHZ)
`define OTPP_OVER_FACTOR    3
`define OTPP_MAX_TRIES      5'h19
`define OTPP_SETUP_US       2
`define OTPP_SETUP_CYC      (`OTPP_SETUP_US * `OTPP_CLK_MHZ)
`define OTPP_ACCESS_NS      300
`define OTPP_ACCESS_CYC     ((`OTPP_ACCESS_NS + 9) / 10)
`define OTPP_ADDR_W         14
`define OTPP_DATA_W         8
`define OTPP_ID_SEL_BIT     0
`define OTPP_SIG_SEL_BIT    9
`define OTPP_PARITY_BIT     7
`define OTPP_BLANK_BYTE     8'hFF

`endif

// ### otpp_pkg.sv
// Purpose: Types shared by the OTP ROM programmer.
// Assumes: Nothing beyond the params header.
// Notes:   Supply selects drive external level switches.
package otpp_pkg;

  typedef enum logic [1:0] {
    OTPP_VPP_READ,
    OTPP_VPP_PROG
  } otpp_vpp_type;

  typedef struct packed {
    logic       vcc_high;
    logic       vpp_high;
    logic       sig_raise;
  } otpp_supply_type;

  typedef struct packed {
    logic       ce_n;
    logic       oe_n;
    logic       pgm_n;
  } otpp_ctrl_type;

  typedef enum logic [1:0] {
    OTPP_CMD_PROGRAM,
    OTPP_CMD_COMPARE,
    OTPP_CMD_IDENT,
    OTPP_CMD_NONE
  } otpp_cmd_type;

endpackage : otpp_pkg

// ### otpp_timer.sv
// Purpose: Loadable down counter used for pulses and setup delays.
// Assumes: Load and count are on CLK_IN.
// Notes:   Done is a one-cycle pulse when the count reaches zero.
`timescale 1ns/10ps
module otpp_timer (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        rstn_in,
  // Control
  input  wire logic        load_in,
  input  wire logic [31:0] count_in,
  // Status
  output logic             done_out
);

  logic [31:0] cnt_q;
  logic        run_q;

  wire         at_one = (cnt_q == 32'h0000_0001);

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      cnt_q    <= 32'h0000_0000;
      run_q    <= 1'b0;
      done_out <= 1'b0;
    end else if (load_in) begin
      cnt_q    <= count_in;
      run_q    <= 1'b1;
      done_out <= 1'b0;
    end else begin
      done_out <= run_q && at_one;
      if (run_q) begin
        cnt_q <= cnt_q - 32'h0000_0001;
      end
      if (at_one) begin
        run_q <= 1'b0;
      end
    end
  end

endmodule : otpp_timer

// ### otpp_monitor.sv
// Purpose: Pin-level checks on the OTP ROM programmer.
// Assumes: One clock domain with a synchronous active-low reset.
// Notes:   Strobe-low cycles are counted to judge each pulse width.
`timescale 1ns/10ps
module otpp_monitor #(
  parameter int unsigned PULSE_CYC = 20
) (
  // Clock, reset and status
  input wire logic        CLK_IN,
  input wire logic        RSTN_IN,
  input wire logic [4:0]  TRIES_OUT,
  // Device pins
  input wire logic [13:0] ADDR_OUT,
  input wire logic        CHIP_SEL_N_OUT,
  input wire logic        OUT_GATE_N_OUT,
  input wire logic        PROGRAM_STROBE_N_OUT,
  input wire logic        VCC_HIGH_OUT,
  input wire logic        VPP_HIGH_OUT,
  input wire logic        SIGNATURE_SELECT_RAISE_OUT,
  input wire logic        DQ_OE_OUT
);
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RSTN_IN);
  logic [31:0] low_len_q;
  // Counts sampled strobe-low cycles; cleared while the strobe is high.
  always_ff @(posedge CLK_IN) begin
    if (!RSTN_IN || PROGRAM_STROBE_N_OUT) begin
      low_len_q <= 32'h0000_0000;
    end else begin
      low_len_q <= low_len_q + 32'h0000_0001;
    end
  end
  AST_PULSE_LEN: assert property (
    $rose(PROGRAM_STROBE_N_OUT) |->
    low_len_q == PULSE_CYC || low_len_q == 3 * TRIES_OUT * PULSE_CYC)
    else $error("program pulse has a wrong width");
  AST_PROG_MODE: assert property (
    !PROGRAM_STROBE_N_OUT |->
    !CHIP_SEL_N_OUT && VPP_HIGH_OUT && OUT_GATE_N_OUT)
    else $error("strobe low outside programming mode");
  AST_PROG_SUPPLY: assert property (
    !PROGRAM_STROBE_N_OUT |-> VCC_HIGH_OUT)
    else $error("strobe low without raised main supply");
  AST_DATA_DRIVE: assert property (
    !PROGRAM_STROBE_N_OUT |-> DQ_OE_OUT)
    else $error("data not driven during a pulse");
  AST_VERIFY_QUIET: assert property (
    !OUT_GATE_N_OUT |-> PROGRAM_STROBE_N_OUT && !DQ_OE_OUT)
    else $error("output gate low while strobe or data driven");
  AST_TRY_LIMIT: assert property (
    !PROGRAM_STROBE_N_OUT |-> TRIES_OUT <= 5'h19)
    else $error("more than the allowed initial pulses");
  AST_ID_ADDR: assert property (
    SIGNATURE_SELECT_RAISE_OUT |-> ADDR_OUT[13:1] == 13'h0000)
    else $error("upper address lines set in identification");
  AST_ID_SUPPLY: assert property (
    SIGNATURE_SELECT_RAISE_OUT |-> PROGRAM_STROBE_N_OUT && !VPP_HIGH_OUT)
    else $error("identification mixed with programming");
endmodule : otpp_monitor
bind otpp_programmer otpp_monitor #(.PULSE_CYC(PULSE_CYC)) u_otpp_monitor (
  .CLK_IN, .RSTN_IN, .TRIES_OUT, .ADDR_OUT, .CHIP_SEL_N_OUT, .OUT_GATE_N_OUT,
  .PROGRAM_STROBE_N_OUT, .VCC_HIGH_OUT, .VPP_HIGH_OUT,
  .SIGNATURE_SELECT_RAISE_OUT, .DQ_OE_OUT);

// ### otpp_rom_model.sv
// Purpose: Behavioural OTP ROM answering the programmer's pins.
// Assumes: need sets how many pulses a cell takes before it sticks.
// Notes:   Identification codes are arbitrary odd-parity values.
`timescale 1ns/10ps
module otpp_rom_model #(
  parameter logic [7:0] MAKER_CODE = 8'h31,
  parameter logic [7:0] PART_CODE  = 8'hC1
) (
  // Device pins
  input  wire logic [13:0] addr_in,
  input  wire logic        ce_n_in,
  input  wire logic        oe_n_in,
  input  wire logic        pgm_n_in,
  input  wire logic        vpp_high_in,
  input  wire logic        sig_raise_in,
  input  wire logic [7:0]  dq_in,
  output logic [7:0]       dq_out,
  output logic             dq_en_out
);
  logic [7:0] mem [0:16383];
  int         cnt [0:16383];
  int         need = 1;
  logic [7:0] held_d;
  logic [13:0] held_a;
  logic       armed;
  initial foreach (mem[i]) mem[i] = 8'hFF;
  // Latching while the strobe is low avoids racing the pins at its release.
  always_latch if (!pgm_n_in) begin
    armed = !ce_n_in && vpp_high_in;
    held_d = dq_in;
    held_a = addr_in;
  end
  always @(posedge pgm_n_in) if (armed) begin
    cnt[held_a]++;
    if (cnt[held_a] >= need) mem[held_a] &= held_d;
  end
  assign dq_en_out = !ce_n_in && !oe_n_in && pgm_n_in;
  assign dq_out = !sig_raise_in ? mem[addr_in] :
                  addr_in[0] ? PART_CODE : MAKER_CODE;
endmodule : otpp_rom_model

// ### test_otpp_programmer.sv
// Purpose: Self-checking bench for the OTP ROM programmer.
// Assumes: Short pulses via PULSE_CYC, inputs driven at falling edges.
// Notes:   Expected results wait in queues for a watcher process.
`timescale 1ns/10ps
module test_otpp_programmer;
  localparam logic [7:0] MAKER = 8'h5B; // Arbitrary value.
  localparam logic [7:0] PART  = 8'hC1; // Arbitrary value.
  logic clk, rstn = 0, start = 0, busy, done, fail, dreq, rv, pok;
  logic [1:0] cmd = '0;
  logic [13:0] fa = '0, la = '0, cur, adr, base;
  logic [7:0] wd = '0, rd_d, dqo, dqb, dvd, d0, d1, d2;
  logic [4:0] tries;
  logic ce, oe, pg, vh, ph, sr, doe, den, rd_on = 0, fchk = 0;
  int fails = 0, comparisons = 0, cyc = 0;
  logic [8:0] eq[$];
  logic fq[$];
  // Nobody driving: a changing pattern so a stale value never passes.
  assign dqb = doe ? dqo : den ? dvd : cyc[7:0];
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  otpp_programmer #(.PULSE_CYC(20)) u_otpp_programmer (.CLK_IN(clk),
    .RSTN_IN(rstn), .START_IN(start), .CMD_IN(cmd), .FIRST_ADDR_IN(fa),
    .LAST_ADDR_IN(la), .WDATA_IN(wd), .BUSY_OUT(busy), .DONE_OUT(done),
    .FAIL_OUT(fail), .DATA_REQ_OUT(dreq), .CUR_ADDR_OUT(cur),
    .RDATA_OUT(rd_d), .RDATA_VALID_OUT(rv), .PARITY_OK_OUT(pok),
    .TRIES_OUT(tries), .ADDR_OUT(adr), .CHIP_SEL_N_OUT(ce),
    .OUT_GATE_N_OUT(oe), .PROGRAM_STROBE_N_OUT(pg), .VCC_HIGH_OUT(vh),
    .VPP_HIGH_OUT(ph), .SIGNATURE_SELECT_RAISE_OUT(sr), .DQ_IN(dqb),
    .DQ_OUT(dqo), .DQ_OE_OUT(doe));
  otpp_rom_model #(.MAKER_CODE(MAKER), .PART_CODE(PART)) u_otpp_rom_model (
    .addr_in(adr), .ce_n_in(ce), .oe_n_in(oe), .pgm_n_in(pg),
    .vpp_high_in(ph), .sig_raise_in(sr), .dq_in(dqb), .dq_out(dvd),
    .dq_en_out(den));
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wrap_up;
    $display("comparisons %0d, mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : wrap_up
  always @(negedge clk) begin
    cyc++;
    if (fchk) chk({8'h0, fail}, {8'h0, fq.pop_front()});
    fchk = done;
    if (rv && rd_on) chk({pok, rd_d}, eq.pop_front());
    if (cyc == 30000) begin
      fails++;
      wrap_up();
    end
  end
  task automatic go(input logic [1:0] c, input logic [13:0] a0, a1,
                    input logic [7:0] d);
    @(negedge clk);
    start = 1;
    cmd = c;
    fa = a0;
    la = a1;
    wd = d;
    @(negedge clk);
    start = 0;
  endtask : go
  task automatic await_evt;
    int k = 0;
    repeat (2) @(negedge clk);
    while (!done && !dreq && k < 5000) begin
      @(negedge clk);
      k++;
    end
    if (k >= 5000) fails++;
  endtask : await_evt
  task automatic prog(input logic [13:0] a, input logic [7:0] x, y,
                      input logic two, input logic bad);
    rd_on = 0;
    fq.push_back(bad);
    go(2'h0, a, a + {13'h0, two}, x);
    await_evt();
    if (two && dreq) begin
      chk({4'h0, tries},
          (x == 8'hFF) ? 9'h001 : 9'(u_otpp_rom_model.need));
      chk(cur[8:0], a[8:0]);
      go(2'h0, a, a + 14'h1, y);
      await_evt();
    end
    repeat (3) @(negedge clk);
  endtask : prog
  task automatic rd(input logic [1:0] c, input logic [13:0] a0, a1);
    rd_on = 1;
    fq.push_back(1'b0);
    go(c, a0, a1, 8'h0);
    await_evt();
    repeat (3) @(negedge clk);
  endtask : rd
  initial begin
    void'($urandom(32'h45E4));
    base = 14'($urandom_range(16000, 8));
    d0 = 8'($urandom);
    d1 = 8'($urandom);
    d2 = d0 & 8'($urandom);
    repeat (12) @(negedge clk);
    rstn = 1;
    repeat (4) eq.push_back(9'h0FF);
    rd(2'h1, base, base + 14'h3);
    $display("test blank read done");
    u_otpp_rom_model.need = 3;
    prog(base, d0, d1, 1'b1, 1'b0);
    prog(base, d2, 8'h0, 1'b0, 1'b0);
    eq.push_back({^(d0 & d2), d0 & d2});
    eq.push_back({^d1, d1});
    eq.push_back(9'h0FF);
    rd(2'h1, base, base + 14'h2);
    $display("test program and compare done");
    u_otpp_rom_model.need = 40;
    prog(base - 14'h5, 8'h00, 8'h00, 1'b0, 1'b1);
    eq.push_back(9'h0FF);
    rd(2'h1, base - 14'h5, base - 14'h5);
    $display("test pulse limit done");
    eq.push_back({1'b1, MAKER});
    eq.push_back({1'b1, PART});
    rd(2'h2, 14'h0, 14'h1);
    $display("test identification done");
    go(2'h3, base, base, 8'h0);
    repeat (3) @(negedge clk);
    chk({8'h0, busy}, 9'h0);
    $display("test ignored command done");
    wrap_up();
  end
endmodule : test_otpp_programmer
